//--- dv/fault_supervisor_tb.sv
// Self-checking bench for the fault supervisor
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin checks++; if ((gt) !== (ex)) begin \
  $display("BAD %s exp %h got %h", nm, ex, gt); errCount++; end end
module fault_supervisor_tb;
  import fault_sup_pkg::*;
  logic        clk;
  logic        rst;
  logic        reqValid;
  comm_state_t reqState;
  logic [4:0]  inj;
  logic        inputRefresh;
  logic        outputRefresh;
  logic        dcEvent;
  logic        faultClear;
  comm_state_t commState;
  logic [7:0]  faultMain;
  logic [3:0]  faultSub;
  logic        faultActive;
  int          errCount;
  int          checks;

  master_model master (.clk(clk), .reqState(reqState),
    .reqValid(reqValid), .inputRefresh(inputRefresh),
    .outputRefresh(outputRefresh), .dcEvent(dcEvent));

  // Short stale limit keeps the run brief
  fault_supervisor #(.STALE_LIMIT(50), .NUM_SM(4)) DUT (
    .clk(clk), .rst(rst), .reqValid(reqValid), .reqState(reqState),
    .fwMismatch(inj[4]), .bootActionBad(inj[3]), .mbxCfgBad(inj[2]),
    .smCfgBad(inj[1]), .smTypes(8'h00), .inputRefresh(inputRefresh),
    .outputRefresh(outputRefresh), .dcEvent(dcEvent),
    .wdExpired(inj[0]), .faultClear(faultClear), .commState(commState),
    .faultMain(faultMain), .faultSub(faultSub),
    .faultActive(faultActive));

  task automatic wrapUp;
    if (errCount == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input comm_state_t st, input logic [3:0] sub);
    `CHK("commState", st, commState)
    `CHK("faultMain", (sub == SUB_NONE) ? MAIN_NONE : MAIN_CODE, faultMain)
    `CHK("faultSub", sub, faultSub)
    `CHK("faultActive", sub != SUB_NONE, faultActive)
  endtask

  task automatic pulse(input logic [4:0] m);
    @(negedge clk);
    inj = m;
    @(negedge clk);
    inj = 5'h00;
  endtask

  task automatic clr(input comm_state_t st);
    @(negedge clk);
    faultClear = 1'b1;
    @(negedge clk);
    faultClear = 1'b0;
    chk(st, SUB_NONE);
  endtask

  task automatic waitFault;
    for (int i = 0; i < 60 && faultActive !== 1'b1; i++) @(negedge clk);
  endtask

  task automatic toOp;
    master.request(ST_PREOP);
    master.request(ST_SAFEOP);
    master.request(ST_OP);
    chk(ST_OP, SUB_NONE);
  endtask

  task automatic testInit;
    repeat (5) @(negedge clk);
    chk(ST_INIT, SUB_NONE);
    pulse(5'h10);
    chk(ST_INIT, SUB_FIRMWARE);
    clr(ST_INIT);
    @(negedge clk);
    inj = 5'h08;
    master.request(ST_BOOT);
    chk(ST_INIT, SUB_BOOT_MBX);
    inj = 5'h00;
    clr(ST_INIT);
  endtask

  task automatic testPreop;
    master.request(ST_PREOP);
    chk(ST_PREOP, SUB_NONE);
    // Mailbox and sync manager faults together: Init wins
    pulse(5'h06);
    chk(ST_INIT, SUB_PREOP_MBX);
    clr(ST_INIT);
    toOp();
    pulse(5'h02);
    chk(ST_PREOP, SUB_SM_CFG);
    clr(ST_PREOP);
  endtask

  task automatic testOpFaults;
    toOp();
    pulse(5'h01);
    chk(ST_SAFEOP, SUB_WATCHDOG);
    clr(ST_SAFEOP);
    master.request(ST_OP);
    master.dcOnly = 1'b1;
    waitFault();
    master.dcOnly = 1'b0;
    chk(ST_SAFEOP, SUB_SYNC);
    clr(ST_SAFEOP);
  endtask

  task automatic testStale(input logic inp, input logic [3:0] sub);
    master.request(ST_OP);
    if (inp) master.inEn = 1'b0;
    else master.outEn = 1'b0;
    // Still under the limit since the last refresh
    repeat (40) @(negedge clk);
    chk(ST_OP, SUB_NONE);
    waitFault();
    chk(ST_SAFEOP, sub);
    master.inEn = 1'b1;
    master.outEn = 1'b1;
    // Stale flag stands until the next refresh; while it stands it would beat the clear
    repeat (10) @(negedge clk);
    clr(ST_SAFEOP);
  endtask

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  initial begin
    #20000;
    errCount++;
    wrapUp();
  end

  initial begin
    errCount = 0;
    checks = 0;
    inj = 5'h00;
    faultClear = 1'b0;
    rst = 1'b1;
    repeat (10) @(negedge clk);
    rst = 1'b0;
    testInit();
    testPreop();
    testOpFaults();
    testStale(1'b0, SUB_NO_OUTPUT);
    testStale(1'b1, SUB_NO_INPUT);
    wrapUp();
  end
endmodule

//--- dv/master_model.sv
// Network master model: state requests and cyclic process data
`timescale 1ns/1ps
module master_model
  import fault_sup_pkg::*;
(
  // Clock
  input  wire logic                 clk,
  // Transition requests
  output fault_sup_pkg::comm_state_t reqState,
  output logic                      reqValid,
  // Process data and clock events
  output logic                      inputRefresh,
  output logic                      outputRefresh,
  output logic                      dcEvent
);
  logic inEn;
  logic outEn;
  logic dcOnly;
  int   cnt;

  initial begin
    reqValid = 1'b0;
    reqState = ST_INIT;
    inputRefresh = 1'b0;
    outputRefresh = 1'b0;
    dcEvent = 1'b0;
    inEn = 1'b1;
    outEn = 1'b1;
    dcOnly = 1'b0;
    cnt = 0;
  end

  task automatic request(input comm_state_t s);
    @(negedge clk);
    reqValid = 1'b1;
    reqState = s;
    @(negedge clk);
    reqValid = 1'b0;
  endtask

  // clock event paired with output update
  // Stray clock event only when asked, to provoke a sync fault
  always @(negedge clk) begin
    cnt <= (cnt + 1) % 8;
    inputRefresh <= inEn && cnt == 0;
    outputRefresh <= outEn && cnt == 0;
    dcEvent <= (outEn && cnt == 0) || (dcOnly && cnt == 4);
  end
endmodule

//--- hw/fault_supervisor.sv
// Fault supervisor for the slave communication state machine
// ------------------------------------------------------------------
// ------------------------------------------------------------------
`timescale 1ns/1ps
module fault_supervisor
  import fault_sup_pkg::*;
#(
  parameter int STALE_LIMIT = fault_sup_pkg::STALE_CYCLES,
  parameter int NUM_SM      = 4
) (
  // Clock and reset
  input  wire logic                      clk,
  input  wire logic                      rst,
  // Master transition requests
  input  wire logic                      reqValid,
  input  wire fault_sup_pkg::comm_state_t reqState,
  // Configuration checks
  input  wire logic                      fwMismatch,
  input  wire logic                      bootActionBad,
  input  wire logic                      mbxCfgBad,
  input  wire logic                      smCfgBad,
  input  wire logic [2*NUM_SM-1:0]       smTypes,
  // Process data and clock events
  input  wire logic                      inputRefresh,
  input  wire logic                      outputRefresh,
  input  wire logic                      dcEvent,
  input  wire logic                      wdExpired,
  // Fault clear
  input  wire logic                      faultClear,
  // Status
  output fault_sup_pkg::comm_state_t     commState,
  output logic [7:0]                     faultMain,
  output logic [3:0]                     faultSub,
  output logic                           faultActive
);

  import fault_sup_pkg::*;

  // ----------------------------------------------------------------
  // Staleness timers
  // ----------------------------------------------------------------
  logic inStale;
  logic outStale;

  stale_timer #(.W(TIMER_W), .LIMIT(STALE_LIMIT)) u_in_timer (
    .clk     (clk),
    .rst     (rst),
    .refresh (inputRefresh),
    .stale   (inStale)
  );

  stale_timer #(.W(TIMER_W), .LIMIT(STALE_LIMIT)) u_out_timer (
    .clk     (clk),
    .rst     (rst),
    .refresh (outputRefresh),
    .stale   (outStale)
  );

  // ----------------------------------------------------------------
  // Sync check: each clock event must follow one output update
  // ----------------------------------------------------------------
  logic pendOut_ff;
  logic nxt_pendOut;
  logic syncErr;

  always_comb begin
    nxt_pendOut = pendOut_ff;
    syncErr     = 1'b0;
    if (dcEvent && !outputRefresh && !pendOut_ff) begin
      syncErr = 1'b1;
    end else if (outputRefresh && pendOut_ff && !dcEvent) begin
      syncErr = 1'b1;
    end
    if (dcEvent) begin
      nxt_pendOut = 1'b0;
    end else if (outputRefresh) begin
      nxt_pendOut = 1'b1;
    end
  end

  function automatic logic typeBad(input logic [2*NUM_SM-1:0] t);
    // All four 2-bit codes are legal today; width kept for growth
    logic bad;
    bad = 1'b0;
    for (int i = 0; i < NUM_SM; i++) begin
      if (t[2*i +: 2] != SM_MBX_OUT && t[2*i +: 2] != SM_MBX_IN &&
          t[2*i +: 2] != SM_PD_OUT  && t[2*i +: 2] != SM_PD_IN) begin
        bad = 1'b1;
      end
    end
    return bad;
  endfunction

  // ----------------------------------------------------------------
  // State and fault record
  // ----------------------------------------------------------------
  comm_state_t state_ff;
  comm_state_t nxt_state;
  logic [7:0]  main_ff;
  logic [7:0]  nxt_main;
  logic [3:0]  sub_ff;
  logic [3:0]  nxt_sub;
  logic        act_ff;
  logic        nxt_act;
  logic        hit;
  logic [3:0]  hitSub;
  comm_state_t tgt;

  function automatic comm_state_t lower(input comm_state_t a,
                                        input comm_state_t b);
    // Boot ranks below Pre-Op, just above Init as lowest
    if (a == ST_INIT || a == ST_BOOT) begin
      return (b == ST_INIT) ? b : a;
    end
    if (b == ST_INIT || b == ST_BOOT) begin
      return b;
    end
    return (a < b) ? a : b;
  endfunction

  always_comb begin
    hit    = 1'b0;
    hitSub = SUB_NONE;
    // only a master request moves the state forward
    tgt    = state_ff;
    if (reqValid) begin
      tgt = reqState;
    end
    // firmware hold in Boot or Init
    if (fwMismatch && (state_ff == ST_INIT || state_ff == ST_BOOT)) begin
      hit    = 1'b1;
      hitSub = SUB_FIRMWARE;
      tgt    = state_ff;
    end
    if (bootActionBad && reqValid && reqState == ST_BOOT &&
        state_ff == ST_INIT) begin
      if (!hit) hitSub = SUB_BOOT_MBX;
      hit = 1'b1;
      tgt = ST_INIT;
    end
    if (mbxCfgBad && state_ff == ST_PREOP) begin
      if (!hit) hitSub = SUB_PREOP_MBX;
      hit = 1'b1;
      tgt = ST_INIT;
    end
    if (typeBad(smTypes) && state_ff == ST_PREOP) begin
      if (!hit) hitSub = SUB_SM_TYPE;
      hit = 1'b1;
      tgt = ST_INIT;
    end
    // sync manager config Pre-Op and above
    if (smCfgBad && (state_ff == ST_PREOP || state_ff == ST_SAFEOP ||
                     state_ff == ST_OP)) begin
      if (!hit) hitSub = SUB_SM_CFG;
      hit = 1'b1;
      tgt = lower(tgt, ST_PREOP);
    end
    if (inStale) begin
      if (!hit) hitSub = SUB_NO_INPUT;
      hit = 1'b1;
      tgt = (state_ff == ST_OP) ? lower(tgt, ST_SAFEOP) : tgt;
    end
    if (outStale) begin
      if (!hit) hitSub = SUB_NO_OUTPUT;
      hit = 1'b1;
      tgt = (state_ff == ST_OP) ? lower(tgt, ST_SAFEOP) : tgt;
    end
    if (syncErr) begin
      if (!hit) hitSub = SUB_SYNC;
      hit = 1'b1;
      tgt = (state_ff == ST_OP) ? lower(tgt, ST_SAFEOP) : tgt;
    end
    if (wdExpired && state_ff == ST_OP) begin
      if (!hit) hitSub = SUB_WATCHDOG;
      hit = 1'b1;
      tgt = lower(tgt, ST_SAFEOP);
    end
    // first detected fault kept; lowest state applied
    nxt_state = tgt;
    nxt_main  = main_ff;
    nxt_sub   = sub_ff;
    nxt_act   = act_ff;
    // hold code until cleared; a new fault beats the clear
    if (faultClear) begin
      nxt_main = MAIN_NONE;
      nxt_sub  = SUB_NONE;
      nxt_act  = 1'b0;
    end
    if (hit && (!act_ff || faultClear)) begin
      nxt_main = MAIN_CODE;
      nxt_sub  = hitSub;
      nxt_act  = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_ff   <= ST_INIT;
      main_ff    <= MAIN_NONE;
      sub_ff     <= SUB_NONE;
      act_ff     <= 1'b0;
      pendOut_ff <= 1'b0;
    end else begin
      state_ff   <= nxt_state;
      main_ff    <= nxt_main;
      sub_ff     <= nxt_sub;
      act_ff     <= nxt_act;
      pendOut_ff <= nxt_pendOut;
    end
  end

  assign commState   = state_ff;
  assign faultMain   = main_ff;
  assign faultSub    = sub_ff;
  assign faultActive = act_ff;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_fw_hold: assert property (
    fwMismatch && state_ff == ST_INIT && !faultClear |=>
      state_ff == ST_INIT && act_ff)
    else $error("firmware fault did not hold Init");
  a_boot_back: assert property (
    bootActionBad && reqValid && reqState == ST_BOOT &&
    state_ff == ST_INIT |=> state_ff == ST_INIT)
    else $error("bad boot action entered Boot");
  a_mbx_init: assert property (
    mbxCfgBad && state_ff == ST_PREOP |=> state_ff == ST_INIT)
    else $error("mailbox fault did not return to Init");
  a_smcfg_preop: assert property (
    smCfgBad && state_ff == ST_OP && !mbxCfgBad && !reqValid |=>
      state_ff == ST_PREOP)
    else $error("sync manager fault did not force Pre-Op");
  a_wd_safeop: assert property (
    wdExpired && state_ff == ST_OP && !smCfgBad && !reqValid |=>
      state_ff == ST_SAFEOP)
    else $error("watchdog did not drop to Safe-Op");
  a_stale_low: assert property (
    inStale && state_ff == ST_SAFEOP && !smCfgBad && !reqValid |=>
      state_ff == ST_SAFEOP)
    else $error("stale input changed lower state");
  a_sync_code: assert property (
    syncErr && !act_ff && !inStale && !outStale && !smCfgBad &&
    !wdExpired && !fwMismatch && !mbxCfgBad && !bootActionBad |=>
      sub_ff == SUB_SYNC && main_ff == MAIN_CODE)
    else $error("sync fault code wrong");
  a_code_hold: assert property (
    act_ff && !faultClear |=> $stable(sub_ff) && act_ff)
    else $error("fault code lost before clear");
  a_no_advance: assert property (
    !reqValid |=> !(state_ff == ST_OP && $past(state_ff) != ST_OP))
    else $error("state advanced without request");

  c_op_wd:    cover property (state_ff == ST_OP ##1 state_ff == ST_SAFEOP);
  c_clear:    cover property (act_ff ##1 !act_ff);
  c_stale:    cover property (inStale && state_ff == ST_OP);
  c_boot_bad: cover property (bootActionBad && reqValid &&
                              reqState == ST_BOOT);

endmodule

//--- hw/stale_timer.sv
// Staleness timer: flags when no refresh arrived for more than LIMIT cycles
`timescale 1ns/1ps
module stale_timer #(
  parameter int W     = 28,
  parameter int LIMIT = 125000000
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Refresh and result
  input  wire logic refresh,
  output logic      stale
);

  logic [W-1:0] cnt_ff;
  logic [W-1:0] nxt_cnt;
  logic         stale_ff;
  logic         nxt_stale;

  always_comb begin
    nxt_cnt   = cnt_ff;
    nxt_stale = stale_ff;
    if (refresh) begin
      nxt_cnt   = '0;
      nxt_stale = 1'b0;
    end else if (cnt_ff >= W'(LIMIT)) begin
      nxt_stale = 1'b1;
    end else begin
      nxt_cnt = cnt_ff + W'(1);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_ff   <= '0;
      stale_ff <= 1'b0;
    end else begin
      cnt_ff   <= nxt_cnt;
      stale_ff <= nxt_stale;
    end
  end

  assign stale = stale_ff;

endmodule

//--- shared/fault_sup_pkg.sv
// Package: states, fault codes and timing for the fault supervisor
package fault_sup_pkg;

  // ----------------------------------------------------------------
  // Communication state machine states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_INIT,
    ST_PREOP,
    ST_BOOT,
    ST_SAFEOP,
    ST_OP
  } comm_state_t;

  // ----------------------------------------------------------------
  // Fault codes (main byte, sub nibble)
  // ----------------------------------------------------------------
  localparam logic [7:0] MAIN_CODE      = 8'h81;
  localparam logic [7:0] MAIN_NONE      = 8'h00;
  localparam logic [3:0] SUB_NONE       = 4'h0;
  localparam logic [3:0] SUB_FIRMWARE   = 4'h4;
  localparam logic [3:0] SUB_BOOT_MBX   = 4'h5;
  localparam logic [3:0] SUB_PREOP_MBX  = 4'h6;
  localparam logic [3:0] SUB_SM_CFG     = 4'h7;
  localparam logic [3:0] SUB_NO_INPUT   = 4'h8;
  localparam logic [3:0] SUB_NO_OUTPUT  = 4'h9;
  localparam logic [3:0] SUB_SYNC       = 4'hA;
  localparam logic [3:0] SUB_WATCHDOG   = 4'hB;
  localparam logic [3:0] SUB_SM_TYPE    = 4'hC;

  // ----------------------------------------------------------------
  // Sync manager types accepted in Pre-Op
  // ----------------------------------------------------------------
  localparam logic [1:0] SM_MBX_OUT = 2'h0;
  localparam logic [1:0] SM_MBX_IN  = 2'h1;
  localparam logic [1:0] SM_PD_OUT  = 2'h2;
  localparam logic [1:0] SM_PD_IN   = 2'h3;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 8;
  localparam int STALE_TIME_MS   = 1000;
  localparam int STALE_CYCLES    = STALE_TIME_MS * 1000000 / CLK_PERIOD_NS;
  localparam int TIMER_W         = 28;

endpackage
